// ==== verilog/pdt_defines.vh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PDT_DEFINES_VH
`define PDT_DEFINES_VH

// Register indices (byte addresses on the plain port)
`define PDT_ADDR_LEN_LOW 4'h2
`define PDT_ADDR_LEN_MID 4'h3
`define PDT_ADDR_LEN_HIGH 4'h4
`define PDT_ADDR_FREE_LOW 4'h5
`define PDT_ADDR_FREE_MID 4'h6
`define PDT_ADDR_FREE_HIGH 4'h7
`define PDT_ADDR_WAIT 4'h8
`define PDT_ADDR_SETTLE 4'h1
`define PDT_ADDR_CTRL 4'h9
`define PDT_ADDR_INT_STATUS 4'ha
`define PDT_ADDR_INT_MASK 4'hb

// Field positions
`define PDT_HOLD_BIT 7
`define PDT_GATE_BIT 3
`define PDT_WAIT_MSB 1
`define PDT_WAIT_LSB 0
`define PDT_CTRL_START_BIT 0
`define PDT_CTRL_CANCEL_BIT 1
`define PDT_CTRL_SLEEPREQ_BIT 2
`define PDT_CTRL_ACTIVE_BIT 7
`define PDT_INT_DONE_BIT 0

// Reset values
`define PDT_RST_LEN_BYTE 8'h00
`define PDT_RST_WAIT 2'h3
`define PDT_RST_GATE 1'b1
`define PDT_RST_SETTLE 4'h0
`define PDT_RST_MASK 8'h01

// Timing
`define PDT_SLOW_CLK_HZ 32768
`define PDT_MAIN_CLK_HZ 25000000
`define PDT_SETTLE_STEP 16
`define PDT_CLKS_PER_WAIT 2

`endif

// ==== verilog/pdt_edge_sync.v ====
// Two-stage synchroniser with rising-edge pulse for the slow crystal clock
`timescale 1ns/1ps
module pdt_edge_sync (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Slow clock in, one-cycle tick out
    input wire i_slow_clk,
    output reg o_tick
);
    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            o_tick <= 1'b0;
        end else begin
            meta_reg <= i_slow_clk;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            o_tick <= sync_reg & ~last_reg;
        end
    end
endmodule

// ==== verilog/pdt_wait_gen.v ====
// Flash access stretcher: two main clocks per programmed wait state
`timescale 1ns/1ps
`include "pdt_defines.vh"
module pdt_wait_gen (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Setting and access start
    input wire [1:0] i_wait_code,
    input wire i_start,
    // Access still being stretched
    output reg o_busy
);
    reg [2:0] count_reg;

    // Code value equals the number of wait states
    function [2:0] pdt_wait_cycles;
        input [1:0] code;
        reg [31:0] product;
        begin
            product = {1'b0, code} * `PDT_CLKS_PER_WAIT;
            pdt_wait_cycles = product[2:0];
        end
    endfunction

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= 3'h0;
            o_busy <= 1'b0;
        end else if (i_start && !o_busy) begin
            count_reg <= pdt_wait_cycles(i_wait_code);
            o_busy <= (i_wait_code != 2'h0);
        end else if (o_busy) begin
            count_reg <= count_reg - 3'h1;
            o_busy <= (count_reg != 3'h1);
        end
    end
endmodule

// ==== verilog/pdt_power_down_timing.v ====
// Power-down length timer, free timer, host gate and flash wait control
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pdt_defines.vh"

// How it works
// - Running power-down counts the length down; zero starts the wake settle phase.
// - Length counter steps once per slow crystal clock period.
// - Length bits 15:8 in one byte, 22:16 in bits 6:0 of next.
// - Hold-asleep bit ignores counts; only cancel or request drop ends.
// - A 24-bit free timer advances on the slow crystal clock.
// - Only the hardware reset clears the free timer.
// - Free timer read as low, middle and high byte registers.
// - Host gate bit 3 resets to one; clear blocks host memory access.
// - Flash waits stretch core flash accesses, and host flash accesses while the host gate bit is set.
// - Each flash wait adds two main clock periods.
// - Wait field resets to 11b; code equals wait state count.
// - Low length byte in its own register, resetting to zero.
// - Wake settle phase lasts settle count times 16 slow periods.
// - Completion sets the done flag and interrupts the core.
module pdt_power_down_timing (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Register port
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // Slow crystal clock
    input wire i_slow_crystal_clock,
    // Card sleep request level from the host side
    input wire i_card_sleep_request,
    // Flash and host memory access requests
    input wire i_core_flash_start,
    input wire i_host_flash_start,
    input wire i_host_mem_req,
    // Status outputs
    output reg o_sleep_active,
    output reg o_clock_buffer_on,
    output reg o_flash_wait,
    output reg o_host_mem_grant,
    output reg o_irq
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_COUNT = 4'b0010;
    localparam [3:0] ST_SETTLE = 4'b0100;
    localparam [3:0] ST_HOLD = 4'b1000;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [7:0] len_low_reg;
    reg [7:0] len_mid_reg;
    reg [6:0] len_high_reg;
    reg hold_reg;
    reg [22:0] len_cnt_reg;
    reg [3:0] settle_reg;
    reg [7:0] settle_cnt_reg;
    reg [23:0] free_timer_value;
    reg host_memory_gate;
    reg [1:0] nvm_wait_states;
    reg sleep_done_flag;
    reg [7:0] int_mask_reg;
    reg start_pulse;
    reg cancel_pulse;
    reg req_last_reg;
    wire slow_tick;
    wire wait_busy;
    wire done_event;
    wire req_fall;
    wire status_rd;

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    // Sequencer is anywhere but idle
    function pdt_busy;
        input [3:0] state;
        begin
            pdt_busy = (state != ST_IDLE);
        end
    endfunction

    // Length counter has run out
    function pdt_len_zero;
        input [22:0] count;
        begin
            pdt_len_zero = (count == 23'h000000);
        end
    endfunction

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    pdt_edge_sync u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_slow_clk(i_slow_crystal_clock),
        .o_tick(slow_tick)
    );

    pdt_wait_gen u_wait (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wait_code(nvm_wait_states),
        .i_start(i_core_flash_start |
                 (i_host_flash_start & host_memory_gate)),
        .o_busy(wait_busy)
    );

    assign req_fall = req_last_reg & ~i_card_sleep_request;
    assign status_rd = i_rd && (i_addr == `PDT_ADDR_INT_STATUS);
    // A zero settle count ends the phase at once
    assign done_event = (state_reg == ST_SETTLE) &&
                        ((slow_tick && settle_cnt_reg == 8'h00) ||
                         settle_reg == 4'h0);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            len_low_reg <= `PDT_RST_LEN_BYTE;
            len_mid_reg <= `PDT_RST_LEN_BYTE;
            len_high_reg <= 7'h00;
            hold_reg <= 1'b0;
            settle_reg <= `PDT_RST_SETTLE;
            host_memory_gate <= `PDT_RST_GATE;
            nvm_wait_states <= `PDT_RST_WAIT;
            int_mask_reg <= `PDT_RST_MASK;
            start_pulse <= 1'b0;
            cancel_pulse <= 1'b0;
        end else begin
            start_pulse <= 1'b0;
            cancel_pulse <= 1'b0;
            if (i_wr) begin
                if (i_addr == `PDT_ADDR_LEN_LOW) begin
                    len_low_reg <= i_wdata;
                end else if (i_addr == `PDT_ADDR_LEN_MID) begin
                    len_mid_reg <= i_wdata;
                end else if (i_addr == `PDT_ADDR_LEN_HIGH) begin
                    len_high_reg <= i_wdata[6:0];
                    hold_reg <= i_wdata[`PDT_HOLD_BIT];
                end else if (i_addr == `PDT_ADDR_SETTLE) begin
                    settle_reg <= i_wdata[7:4];
                end else if (i_addr == `PDT_ADDR_WAIT) begin
                    host_memory_gate <= i_wdata[`PDT_GATE_BIT];
                    nvm_wait_states <=
                        i_wdata[`PDT_WAIT_MSB:`PDT_WAIT_LSB];
                end else if (i_addr == `PDT_ADDR_CTRL) begin
                    start_pulse <= i_wdata[`PDT_CTRL_START_BIT];
                    cancel_pulse <= i_wdata[`PDT_CTRL_CANCEL_BIT];
                end else if (i_addr == `PDT_ADDR_INT_MASK) begin
                    int_mask_reg <= i_wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Free timer, reset only by the pin
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            free_timer_value <= 24'h000000;
        end else if (slow_tick) begin
            free_timer_value <= free_timer_value + 24'h000001;
        end
    end

    // ------------------------------------------------------------
    // Power-down sequencer
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_pulse) begin
                    state_next = hold_reg ? ST_HOLD : ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (cancel_pulse || req_fall) begin
                    state_next = ST_IDLE;
                end else if (pdt_len_zero(len_cnt_reg)) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (cancel_pulse || req_fall || done_event) begin
                    state_next = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (cancel_pulse || req_fall) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            len_cnt_reg <= 23'h000000;
            settle_cnt_reg <= 8'h00;
            req_last_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_last_reg <= i_card_sleep_request;
            if (state_reg == ST_IDLE) begin
                len_cnt_reg <= {len_high_reg, len_mid_reg,
                                len_low_reg};
            end else if (state_reg == ST_COUNT && slow_tick &&
                         !pdt_len_zero(len_cnt_reg)) begin
                len_cnt_reg <= len_cnt_reg - 23'h000001;
            end
            if (state_reg != ST_SETTLE) begin
                settle_cnt_reg <= {settle_reg, 4'h0} - 8'h01;
            end else if (slow_tick && settle_cnt_reg != 8'h00) begin
                settle_cnt_reg <= settle_cnt_reg - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Done flag, interrupt and outputs
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sleep_done_flag <= 1'b0;
            o_irq <= 1'b0;
            o_sleep_active <= 1'b0;
            o_clock_buffer_on <= 1'b1;
            o_flash_wait <= 1'b0;
            o_host_mem_grant <= 1'b0;
        end else begin
            // Set wins over the clear-on-read
            if (done_event) begin
                sleep_done_flag <= 1'b1;
            end else if (status_rd) begin
                sleep_done_flag <= 1'b0;
            end
            o_irq <= sleep_done_flag &
                     int_mask_reg[`PDT_INT_DONE_BIT];
            o_sleep_active <= pdt_busy(state_reg);
            o_clock_buffer_on <= (state_reg == ST_IDLE) ||
                                 (state_reg == ST_SETTLE);
            o_flash_wait <= wait_busy;
            o_host_mem_grant <= i_host_mem_req &
                                host_memory_gate;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (i_addr == `PDT_ADDR_LEN_LOW) begin
                o_rdata <= len_low_reg;
            end else if (i_addr == `PDT_ADDR_LEN_MID) begin
                o_rdata <= len_mid_reg;
            end else if (i_addr == `PDT_ADDR_LEN_HIGH) begin
                o_rdata <= {hold_reg, len_high_reg};
            end else if (i_addr == `PDT_ADDR_FREE_LOW) begin
                o_rdata <= free_timer_value[7:0];
            end else if (i_addr == `PDT_ADDR_FREE_MID) begin
                o_rdata <= free_timer_value[15:8];
            end else if (i_addr == `PDT_ADDR_FREE_HIGH) begin
                o_rdata <= free_timer_value[23:16];
            end else if (i_addr == `PDT_ADDR_WAIT) begin
                o_rdata <= {4'h0, host_memory_gate, 1'b0,
                            nvm_wait_states};
            end else if (i_addr == `PDT_ADDR_SETTLE) begin
                o_rdata <= {settle_reg, 4'h0};
            end else if (i_addr == `PDT_ADDR_CTRL) begin
                o_rdata <= {pdt_busy(state_reg), 4'h0,
                            i_card_sleep_request, 2'h0};
            end else if (i_addr == `PDT_ADDR_INT_STATUS) begin
                o_rdata <= {7'h00, sleep_done_flag};
            end else if (i_addr == `PDT_ADDR_INT_MASK) begin
                o_rdata <= int_mask_reg;
            end else begin
                o_rdata <= 8'h00;
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule

// ==== tb/pdt_chk.sv ====
// Port-level assertions for the power-down timing block
`timescale 1ns/1ps
module pdt_chk (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Observed ports
    input wire [3:0] i_addr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire i_card_sleep_request,
    input wire i_core_flash_start,
    input wire i_host_flash_start,
    input wire i_host_mem_req,
    input wire o_sleep_active,
    input wire o_clock_buffer_on,
    input wire o_flash_wait,
    input wire o_host_mem_grant,
    input wire o_irq
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_rst);
// ----------------------------------------
// Assertions
// ----------------------------------------
rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
grant_cause_a: assert property (o_host_mem_grant |-> $past(i_host_mem_req))
    else $error("host grant without request");
wait_cause_a: assert property ($rose(o_flash_wait) |->
    ($past(i_core_flash_start, 2) || $past(i_host_flash_start, 2)))
    else $error("flash stretch without start");
wait_bound_a: assert property ($rose(o_flash_wait) |-> ##[1:6] !o_flash_wait)
    else $error("flash stretch too long");
wait_pair_a: assert property ($fell(o_flash_wait) |-> $past(o_flash_wait, 2))
    else $error("flash stretch shorter than two clocks");
buffer_idle_a: assert property (!o_sleep_active && !$past(o_sleep_active)
    |-> o_clock_buffer_on)
    else $error("clock buffer off while idle");
irq_after_a: assert property ($rose(o_irq) |-> ##[0:2] !o_sleep_active)
    else $error("interrupt while still asleep");
sleep_exit_a: assert property ($fell(i_card_sleep_request)
    |-> ##[1:5] !o_sleep_active)
    else $error("sleep not ended by request drop");
// ----------------------------------------
// Coverage
// ----------------------------------------
cover property ($fell(o_sleep_active));
cover property ($rose(o_irq));
cover property ($rose(o_flash_wait));
endmodule

bind pdt_power_down_timing pdt_chk u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_card_sleep_request(i_card_sleep_request),
    .i_core_flash_start(i_core_flash_start),
    .i_host_flash_start(i_host_flash_start),
    .i_host_mem_req(i_host_mem_req), .o_sleep_active(o_sleep_active),
    .o_clock_buffer_on(o_clock_buffer_on), .o_flash_wait(o_flash_wait),
    .o_host_mem_grant(o_host_mem_grant), .o_irq(o_irq)
);

// ==== tb/pdt_core_side.sv ====
// Far-side model: slow crystal source, shortened for simulation
`timescale 1ns/1ps
module pdt_core_side #(
    parameter HALF = 8
) (
    input wire i_clk,
    input wire i_rst,
    output logic o_slow_crystal_clock
);
int cnt;
// Square wave of 2*HALF main clocks, held low in reset
always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        cnt <= 0;
        o_slow_crystal_clock <= 1'b0;
    end else if (cnt == HALF - 1) begin
        cnt <= 0;
        o_slow_crystal_clock <= !o_slow_crystal_clock;
    end else begin
        cnt <= cnt + 1;
    end
end
endmodule

// ==== tb/pdt_power_down_timing_tb_top.sv ====
// Register-level regression for the power-down timing block
`timescale 1ns/1ps
`include "pdt_defines.vh"
module pdt_power_down_timing_tb_top;
// ----------------------------------------
// Signals and instances
// ----------------------------------------
logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, slow;
logic [3:0] i_addr = 4'h0;
logic [7:0] i_wdata = 8'h00, d, v;
logic core_go = 0, host_go = 0, mem_req = 0, sleep_req = 1;
wire [7:0] rdata;
wire active, buf_on, fwait, grant, irq;
int miscompares = 0, samples_checked = 0, n;
pdt_core_side u_core (.i_clk(i_clk), .i_rst(i_rst),
    .o_slow_crystal_clock(slow));
pdt_power_down_timing dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_slow_crystal_clock(slow), .i_card_sleep_request(sleep_req),
    .i_core_flash_start(core_go), .i_host_flash_start(host_go),
    .i_host_mem_req(mem_req), .o_sleep_active(active),
    .o_clock_buffer_on(buf_on), .o_flash_wait(fwait),
    .o_host_mem_grant(grant), .o_irq(irq));
initial forever #20 i_clk = ~i_clk;
// ----------------------------------------
// Bus and check tasks
// ----------------------------------------
task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= x;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
endtask
task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    x = rdata;
endtask
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
        miscompares++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic bit_chk(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
endtask
task automatic run_sleep(output int cyc);
    wr(`PDT_ADDR_CTRL, 8'h01);
    cyc = 0;
    repeat (3) @(posedge i_clk);
    #1;
    while (active === 1'b1 && cyc < 2000) begin
        @(posedge i_clk);
        #1;
        cyc++;
    end
endtask
task automatic flash(input logic host, output int cnt);
    @(posedge i_clk);
    core_go <= !host;
    host_go <= host;
    @(posedge i_clk);
    core_go <= 1'b0;
    host_go <= 1'b0;
    cnt = 0;
    repeat (10) begin
        @(posedge i_clk);
        #1;
        if (fwait === 1'b1) cnt++;
    end
endtask
task automatic close_out;
    $display("checked %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
// ----------------------------------------
// Tests
// ----------------------------------------
initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int a = 2; a < 8; a++) begin
        rd(a[3:0], d);
        chk(d, 8'h00);
    end
    rd(`PDT_ADDR_WAIT, d);
    chk(d & 8'h0b, 8'h0b);
    rd(`PDT_ADDR_INT_MASK, d);
    chk(d, 8'h01);
    wr(`PDT_ADDR_LEN_MID, 8'ha5);
    wr(`PDT_ADDR_LEN_HIGH, 8'hff);
    rd(`PDT_ADDR_LEN_HIGH, d);
    chk(d, 8'hff);
    rd(`PDT_ADDR_LEN_MID, d);
    chk(d, 8'ha5);
    $display("test registers done");
    rd(`PDT_ADDR_FREE_LOW, d);
    wr(`PDT_ADDR_CTRL, 8'h02);
    rd(`PDT_ADDR_FREE_LOW, v);
    bit_chk((v - d) <= 8'h01, 1'b1);
    rd(`PDT_ADDR_FREE_LOW, d);
    repeat (158) @(posedge i_clk);
    rd(`PDT_ADDR_FREE_LOW, v);
    chk(v - d, 8'h0a);
    $display("test free timer done");
    wr(`PDT_ADDR_LEN_LOW, 8'h05);
    wr(`PDT_ADDR_LEN_MID, 8'h00);
    wr(`PDT_ADDR_LEN_HIGH, 8'h00);
    wr(`PDT_ADDR_SETTLE, 8'h10);
    for (int m = 1; m >= 0; m--) begin
        wr(`PDT_ADDR_INT_MASK, {7'h00, m[0]});
        run_sleep(n);
        bit_chk(n >= 300 && n <= 380, 1'b1);
        repeat (2) @(posedge i_clk);
        #1;
        bit_chk(irq, m[0]);
        rd(`PDT_ADDR_INT_STATUS, d);
        chk(d & 8'h01, 8'h01);
        repeat (2) @(posedge i_clk);
        #1;
        bit_chk(irq, 1'b0);
    end
    wr(`PDT_ADDR_SETTLE, 8'h00);
    run_sleep(n);
    bit_chk(n >= 60 && n <= 100, 1'b1);
    rd(`PDT_ADDR_INT_STATUS, d);
    chk(d, 8'h01);
    $display("test sleep count done");
    wr(`PDT_ADDR_LEN_HIGH, 8'h80);
    wr(`PDT_ADDR_LEN_LOW, 8'h01);
    wr(`PDT_ADDR_CTRL, 8'h01);
    repeat (200) @(posedge i_clk);
    #1;
    bit_chk(active, 1'b1);
    bit_chk(buf_on, 1'b0);
    rd(`PDT_ADDR_CTRL, d);
    chk(d, 8'h84);
    @(posedge i_clk);
    sleep_req <= 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    bit_chk(active, 1'b0);
    rd(`PDT_ADDR_INT_STATUS, d);
    chk(d, 8'h00);
    @(posedge i_clk);
    sleep_req <= 1'b1;
    wr(`PDT_ADDR_CTRL, 8'h01);
    repeat (50) @(posedge i_clk);
    wr(`PDT_ADDR_CTRL, 8'h02);
    repeat (6) @(posedge i_clk);
    #1;
    bit_chk(active, 1'b0);
    $display("test hold done");
    for (int c = 0; c < 4; c++) begin
        wr(`PDT_ADDR_WAIT, {4'h0, 2'b10, c[1:0]});
        flash(1'b0, n);
        chk(n[7:0], {5'h00, c[1:0], 1'b0});
    end
    wr(`PDT_ADDR_WAIT, 8'h0a);
    flash(1'b1, n);
    chk(n[7:0], 8'h04);
    @(posedge i_clk);
    mem_req <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    bit_chk(grant, 1'b1);
    wr(`PDT_ADDR_WAIT, 8'h02);
    repeat (2) @(posedge i_clk);
    #1;
    bit_chk(grant, 1'b0);
    flash(1'b1, n);
    chk(n[7:0], 8'h00);
    $display("test flash and gate done");
    rd(`PDT_ADDR_FREE_LOW, d);
    bit_chk(d != 8'h00, 1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`PDT_ADDR_FREE_LOW, d);
    chk(d, 8'h00);
    rd(`PDT_ADDR_WAIT, d);
    chk(d & 8'h0b, 8'h0b);
    $display("test reset done");
    close_out();
end
initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    close_out();
end
endmodule
